/* File: rtl/spc_device.sv */
// The plain strobed port and the register offsets were left to the implementer.
module spc_device
    import spc_pkg::*;
#(
    parameter int NUM_SEC = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    spc_bus_if.dev            bus,
    input  wire logic [15:0]  array_rdata,
    input  wire logic [NUM_SEC-1:0] persistent_sector_bit,
    output logic              persistent_bits_freeze,
    output logic [NUM_SEC-1:0] volatile_sector_bit,
    output logic [1:0]        active_set,
    output logic              in_array_read
);
    localparam int SW = $clog2(NUM_SEC);

    typedef struct packed {
        spc_state_t       st;
        spc_set_t         set;
        logic [NUM_SEC-1:0] vol;
        logic             frz;
        logic [15:0]      rdata;
        logic             rvalid;
    } spc_dev_t;

    spc_dev_t r_ff;
    spc_dev_t nxt_r;

    logic [10:0]   low_a;
    logic [7:0]    cmd;
    logic [SW-1:0] sec;
    logic [NUM_SEC-1:0] prot_any;
    logic [15:0]        stat_word;
    logic [15:0]        bit_word;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // high address ignored except for the sector select
    assign low_a = bus.addr[10:0];
    assign cmd   = bus.wdata[7:0];
    assign sec   = bus.addr[SPC_SEC_LSB +: SW];

    // ------------------------------------------------------------
    // per-sector protection
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_SEC; i++) begin : g_prot
        assign prot_any[i] = r_ff.vol[i] | persistent_sector_bit[i];
    end

    // ------------------------------------------------------------
    // read words
    // ------------------------------------------------------------
    always_comb begin
        stat_word    = SPC_ONES;
        stat_word[0] = ~prot_any[sec];
        stat_word[1] = ~r_ff.vol[sec];
        stat_word[2] = ~persistent_sector_bit[sec];
        bit_word     = SPC_ONES;
        if (r_ff.set == SPC_SET_VOL) begin
            bit_word[0] = ~r_ff.vol[sec];
        end else begin
            bit_word[0] = ~r_ff.frz;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_r        = r_ff;
        nxt_r.rvalid = 1'b0;
        if (bus.wr_en) begin
            if (cmd == SPC_CMD_RESET) begin
                nxt_r.st  = SPC_ST_READ;
                nxt_r.set = SPC_SET_NONE;
            end else begin
                case (r_ff.st)
                    SPC_ST_READ: begin
                        if (low_a == SPC_ADDR_555 && cmd == SPC_CMD_AA) begin
                            nxt_r.st = SPC_ST_UNL1;
                        end
                    end
                    SPC_ST_UNL1: begin
                        if (low_a == SPC_ADDR_2AA && cmd == SPC_CMD_55) begin
                            nxt_r.st = SPC_ST_UNL2;
                        end else begin
                            // broken sequence aborts to read mode
                            nxt_r.st = SPC_ST_READ;
                        end
                    end
                    SPC_ST_UNL2: begin
                        nxt_r.st = SPC_ST_READ;
                        if (low_a == SPC_ADDR_555) begin
                            if (cmd == SPC_CMD_VOL) begin
                                nxt_r.st  = SPC_ST_SET;
                                nxt_r.set = SPC_SET_VOL;
                            end
                            if (cmd == SPC_CMD_FRZ) begin
                                nxt_r.st  = SPC_ST_SET;
                                nxt_r.set = SPC_SET_FRZ;
                            end
                        end
                    end
                    SPC_ST_SET: begin
                        if (cmd == SPC_CMD_PGM) begin
                            nxt_r.st = SPC_ST_PGM;
                        end else if (cmd == SPC_CMD_EXIT) begin
                            nxt_r.st = SPC_ST_EXIT;
                        end else if (cmd == SPC_CMD_STAT && r_ff.set == SPC_SET_VOL) begin
                            nxt_r.st = SPC_ST_STAT;
                        end else begin
                            // no erase or program runs here
                            // so suspend and resume codes stay ignored
                            nxt_r.st = SPC_ST_SET;
                        end
                    end
                    SPC_ST_PGM: begin
                        nxt_r.st = SPC_ST_SET;
                        if (r_ff.set == SPC_SET_VOL) begin
                            if (cmd == SPC_CMD_ZERO) begin
                                nxt_r.vol[sec] = 1'b1;
                            end else if (cmd == SPC_CMD_ONE) begin
                                nxt_r.vol[sec] = 1'b0;
                            end
                        end else if (cmd == SPC_CMD_ZERO) begin
                            nxt_r.frz = 1'b1;
                        end
                    end
                    SPC_ST_EXIT: begin
                        if (cmd == SPC_CMD_ZERO) begin
                            nxt_r.st  = SPC_ST_READ;
                            nxt_r.set = SPC_SET_NONE;
                        end else begin
                            nxt_r.st = SPC_ST_SET;
                        end
                    end
                    SPC_ST_STAT: nxt_r.st = SPC_ST_SET;
                    default: begin
                        nxt_r.st  = SPC_ST_READ;
                        nxt_r.set = SPC_SET_NONE;
                    end
                endcase
            end
        end else if (bus.rd_en) begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rdata  = SPC_ONES;
            case (r_ff.st)
                SPC_ST_STAT: begin
                    nxt_r.rdata = stat_word;
                    nxt_r.st    = SPC_ST_SET;
                end
                SPC_ST_SET: nxt_r.rdata = bit_word;
                default: begin
                    nxt_r.rdata = array_rdata;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // clk_en low holds every register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            r_ff.st     <= SPC_ST_READ;
            r_ff.set    <= SPC_SET_NONE;
            r_ff.vol    <= '0;
            r_ff.frz    <= 1'b0;
            r_ff.rdata  <= '0;
            r_ff.rvalid <= 1'b0;
        end else if (clk_en) begin
            r_ff <= nxt_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.rdata              = r_ff.rdata;
    assign bus.rvalid             = r_ff.rvalid;
    assign persistent_bits_freeze = r_ff.frz;
    assign volatile_sector_bit    = r_ff.vol;
    assign active_set             = r_ff.set;
    // outside any set the array reads
    assign in_array_read          = (r_ff.set == SPC_SET_NONE);
endmodule

/* File: rtl/spc_pkg.sv */
// Function
// - values hex, addresses count 16-bit words
// - command cycles are writes, status reads excepted
// - upper data byte ignored in commands
// - address bits A11 and up ignored
// - array reads need no command cycles
// - host resets from id mode or error
// - erase suspend valid only during erase
// - resume only in matching suspended state
// - host sends full abort-reset sequence
// - every entered set needs an exit
// - set exit is 90 then 00
// - F0 write leaves the command set
// - mode bits one-time; both locks abort
// - protection read: bit0 state, rest ones
// - A0 then 0 sets, 1 clears volatile
// - only first status word valid
// - status word bits 0-2, others ones
// - status query: 60 then sector read
// - host gives A[16:11] for parameter sectors
// - volatile set entry 555/AA 2AA/55 555/E0
// - volatile set read returns sector bit
// - freeze set read returns freeze bit
package spc_pkg;
    localparam int          SPC_AW        = 24;
    localparam int          SPC_DW        = 16;
    localparam int          SPC_SEC_LSB   = 11;
    localparam logic [10:0] SPC_ADDR_555  = 11'h555;
    localparam logic [10:0] SPC_ADDR_2AA  = 11'h2AA;
    localparam logic [7:0]  SPC_CMD_AA    = 8'hAA;
    localparam logic [7:0]  SPC_CMD_55    = 8'h55;
    localparam logic [7:0]  SPC_CMD_VOL   = 8'hE0;
    localparam logic [7:0]  SPC_CMD_FRZ   = 8'h50;
    localparam logic [7:0]  SPC_CMD_PGM   = 8'hA0;
    localparam logic [7:0]  SPC_CMD_STAT  = 8'h60;
    localparam logic [7:0]  SPC_CMD_EXIT  = 8'h90;
    localparam logic [7:0]  SPC_CMD_ZERO  = 8'h00;
    localparam logic [7:0]  SPC_CMD_ONE   = 8'h01;
    localparam logic [7:0]  SPC_CMD_RESET = 8'hF0;
    localparam logic [15:0] SPC_ONES      = 16'hFFFF;

    typedef enum logic [6:0] {
        SPC_ST_READ   = 7'h01,
        SPC_ST_UNL1   = 7'h02,
        SPC_ST_UNL2   = 7'h04,
        SPC_ST_SET    = 7'h08,
        SPC_ST_PGM    = 7'h10,
        SPC_ST_STAT   = 7'h20,
        SPC_ST_EXIT   = 7'h40
    } spc_state_t;

    typedef enum logic [1:0] {
        SPC_SET_NONE = 2'h0,
        SPC_SET_VOL  = 2'h1,
        SPC_SET_FRZ  = 2'h2
    } spc_set_t;
endpackage

/* File: rtl/spc_bus_if.sv */
interface spc_bus_if;
    import spc_pkg::*;
    logic              wr_en;
    logic              rd_en;
    logic [SPC_AW-1:0] addr;
    logic [SPC_DW-1:0] wdata;
    logic [SPC_DW-1:0] rdata;
    logic              rvalid;

    modport dev  (input wr_en, rd_en, addr, wdata, output rdata, rvalid);
    modport host (output wr_en, rd_en, addr, wdata, input rdata, rvalid);
endinterface

/* File: rtl/spc_host.sv */
module spc_host
    import spc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    spc_bus_if.host                bus,
    input  wire logic              req_valid,
    input  wire logic [3:0]        req_op,
    input  wire logic [SPC_AW-1:0] req_addr,
    output logic                   req_ready,
    output logic [15:0]            resp_data,
    output logic                   resp_valid
);
    // ops: 0 array read, 1 enter volatile, 2 enter freeze, 3 set bit,
    // 4 clear bit (no effect in freeze set), 5 status query, 6 set read, 7 exit,
    // 8 abort-reset (unlock pair then F0)
    typedef struct packed {
        logic [3:0]        step;
        logic [3:0]        len;
        logic [3:0]        op;
        logic [SPC_AW-1:0] addr;
        logic              busy;
        logic              wr;
        logic              rd;
        logic [SPC_AW-1:0] a;
        logic [15:0]       d;
        logic [15:0]       resp;
        logic              rv;
    } spc_host_t;

    spc_host_t r_ff;
    spc_host_t nxt_r;

    // ------------------------------------------------------------
    // sequence generator
    // ------------------------------------------------------------
    always_comb begin
        nxt_r    = r_ff;
        nxt_r.wr = 1'b0;
        nxt_r.rd = 1'b0;
        nxt_r.rv = 1'b0;
        if (bus.rvalid) begin
            nxt_r.resp = bus.rdata;
            nxt_r.rv   = 1'b1;
        end
        if (!r_ff.busy && req_valid) begin
            nxt_r.busy = 1'b1;
            nxt_r.op   = req_op;
            nxt_r.addr = req_addr;
            nxt_r.step = 4'h0;
            case (req_op)
                4'h1, 4'h2, 4'h8: nxt_r.len = 4'h3;
                4'h3, 4'h4, 4'h5, 4'h7: nxt_r.len = 4'h2;
                default: nxt_r.len = 4'h1;
            endcase
        end else if (r_ff.busy) begin
            nxt_r.step = r_ff.step + 4'h1;
            nxt_r.a    = '0;
            nxt_r.d    = '0;
            nxt_r.wr   = 1'b1;
            case (r_ff.op)
                4'h1, 4'h2, 4'h8: begin
                    nxt_r.a[10:0] = (r_ff.step == 4'h1) ? SPC_ADDR_2AA : SPC_ADDR_555;
                    case (r_ff.step)
                        4'h0: nxt_r.d[7:0] = SPC_CMD_AA;
                        4'h1: nxt_r.d[7:0] = SPC_CMD_55;
                        default: nxt_r.d[7:0] = (r_ff.op == 4'h1) ? SPC_CMD_VOL
                                              : (r_ff.op == 4'h2) ? SPC_CMD_FRZ
                                              : SPC_CMD_RESET;
                    endcase
                end
                4'h3, 4'h4: begin
                    nxt_r.a      = r_ff.addr;
                    nxt_r.d[7:0] = (r_ff.step == 4'h0) ? SPC_CMD_PGM
                                 : (r_ff.op == 4'h3) ? SPC_CMD_ZERO : SPC_CMD_ONE;
                end
                4'h5: begin
                    nxt_r.a = r_ff.addr;
                    nxt_r.d[7:0] = SPC_CMD_STAT;
                    if (r_ff.step != 4'h0) begin
                        nxt_r.wr = 1'b0;
                        nxt_r.rd = 1'b1;
                    end
                end
                4'h7: nxt_r.d[7:0] = (r_ff.step == 4'h0) ? SPC_CMD_EXIT : SPC_CMD_ZERO;
                default: begin
                    nxt_r.a  = r_ff.addr;
                    nxt_r.wr = 1'b0;
                    nxt_r.rd = 1'b1;
                end
            endcase
            if (nxt_r.step == r_ff.len) begin
                nxt_r.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            r_ff <= '0;
        end else if (clk_en) begin
            r_ff <= nxt_r;
        end
    end

    assign bus.wr_en  = r_ff.wr;
    assign bus.rd_en  = r_ff.rd;
    assign bus.addr   = r_ff.a;
    assign bus.wdata  = r_ff.d;
    assign req_ready  = ~r_ff.busy;
    assign resp_data  = r_ff.resp;
    assign resp_valid = r_ff.rv;
endmodule

/* File: tb/spc_bus_monitor.sv */
module spc_bus_monitor
    import spc_pkg::*;
(
    input logic              core_clk,
    input logic              rst_b,
    input logic              wr_en,
    input logic              rd_en,
    input logic [SPC_AW-1:0] addr,
    input logic [SPC_DW-1:0] wdata,
    input logic [SPC_DW-1:0] rdata,
    input logic              rvalid
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // bus relations
    // ----------------------------------------
    a_strobe_excl: assert property (!(wr_en && rd_en))
        else $error("write and read strobes together");
    a_rd_answer: assert property (rd_en |=> rvalid)
        else $error("read without answer next cycle");
    a_rvalid_cause: assert property (rvalid |-> $past(rd_en))
        else $error("answer without a read");
    a_rvalid_single: assert property (rvalid |=> !rvalid)
        else $error("answer longer than one cycle");
    a_unlock_order: assert property (
        (wr_en && addr[10:0] == 11'h555 && wdata[7:0] == 8'hAA) |=>
        (wr_en && addr[10:0] == 11'h2AA && wdata[7:0] == 8'h55) ##1
        (wr_en && addr[10:0] == 11'h555))
        else $error("unlock cycles out of order");
    a_exit_pair: assert property (
        (wr_en && wdata[7:0] == 8'h90) |=> (wr_en && wdata[7:0] == 8'h00))
        else $error("exit not followed by zero write");
    a_pgm_pair: assert property (
        (wr_en && wdata[7:0] == 8'hA0) |=> (wr_en && wdata[7:1] == 7'h00))
        else $error("program cycle lacks data cycle");
    a_stat_query: assert property (
        (wr_en && wdata[7:0] == 8'h60) |=> rd_en ##1 (rvalid && rdata[15:3] == 13'h1FFF))
        else $error("status query answer wrong");
    c_entry: cover property (wr_en && wdata[7:0] == 8'hE0);
    c_status: cover property (wr_en && wdata[7:0] == 8'h60 ##2 rvalid);
    c_exit: cover property (wr_en && wdata[7:0] == 8'h90);
    c_abort: cover property (wr_en && wdata[7:0] == 8'hF0);
endmodule

/* File: tb/sector_protect_cmd_sets_test.sv */
module sector_protect_cmd_sets_test import spc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic              core_clk = 1'b0;
    logic              rst_b;
    logic              clk_en;
    logic              req_valid;
    logic [3:0]        req_op;
    logic [SPC_AW-1:0] req_addr;
    logic              req_ready;
    logic [15:0]       resp_data;
    logic              resp_valid;
    logic [15:0]       array_rdata;
    logic [15:0]       persistent_sector_bit;
    logic              persistent_bits_freeze;
    logic [15:0]       volatile_sector_bit;
    logic [1:0]        active_set;
    logic              in_array_read;
    logic [15:0]       rd;
    int                num_errors = 0;
    int                checks_done = 0;

    spc_bus_if spc_bus_if_inst ();
    spc_device #(.NUM_SEC(16)) spc_device_inst (
        .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .bus(spc_bus_if_inst),
        .array_rdata(array_rdata), .persistent_sector_bit(persistent_sector_bit),
        .persistent_bits_freeze(persistent_bits_freeze),
        .volatile_sector_bit(volatile_sector_bit), .active_set(active_set),
        .in_array_read(in_array_read));
    spc_host spc_host_inst (
        .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .bus(spc_bus_if_inst),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
        .req_ready(req_ready), .resp_data(resp_data), .resp_valid(resp_valid));
    spc_bus_monitor spc_bus_monitor_inst (
        .core_clk(core_clk), .rst_b(rst_b), .wr_en(spc_bus_if_inst.wr_en),
        .rd_en(spc_bus_if_inst.rd_en), .addr(spc_bus_if_inst.addr),
        .wdata(spc_bus_if_inst.wdata), .rdata(spc_bus_if_inst.rdata),
        .rvalid(spc_bus_if_inst.rvalid));

    always #10 core_clk = ~core_clk;

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one host operation; read data returned for ops 0, 5, 6
    task automatic do_op(input logic [3:0] op, input logic [23:0] a, output logic [15:0] d);
        int n;
        n = 0;
        d = 16'h0000;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        do begin @(negedge core_clk); n++; end while (req_ready !== 1'b1 && n < 20);
        @(posedge core_clk);
        req_valid <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            final_report();
        end
        n = 0;
        do begin @(negedge core_clk); n++; end while (resp_valid !== 1'b1 && n < 12);
        if (op == 4'h0 || op == 4'h5 || op == 4'h6) begin
            if (resp_valid !== 1'b1) begin
                num_errors++;
                final_report();
            end
            d = resp_data;
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req_op = 4'h0;
        req_addr = '0;
        array_rdata = 16'hC3A5;
        persistent_sector_bit = 16'h0004;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        do_op(4'h0, 24'h001234, rd);
        check(rd, 16'hC3A5);
        do_op(4'h1, 24'h000000, rd);
        check({14'h0, active_set}, {14'h0, SPC_SET_VOL});
        check({15'h0, in_array_read}, 16'h0000);
        // clock enable low: a pending set must not run
        @(posedge core_clk);
        clk_en <= 1'b0;
        req_valid <= 1'b1;
        req_op <= 4'h3;
        req_addr <= 24'h001800;
        repeat (3) @(posedge core_clk);
        clk_en <= 1'b1;
        req_valid <= 1'b0;
        @(negedge core_clk);
        check(volatile_sector_bit, 16'h0000);
        check({15'h0, req_ready}, 16'h0001);
        do_op(4'h6, 24'h001800, rd);
        check(rd, 16'hFFFF);
        do_op(4'h3, 24'h8019AB, rd);
        check({15'h0, volatile_sector_bit[3]}, 16'h0001);
        check(volatile_sector_bit, 16'h0008);
        do_op(4'h6, 24'h001800, rd);
        check(rd, 16'hFFFE);
        do_op(4'h5, 24'h001A00, rd);
        check(rd, 16'hFFFC);
        do_op(4'h5, 24'h001000, rd);
        check(rd, 16'hFFFA);
        do_op(4'h4, 24'h401C00, rd);
        check(volatile_sector_bit, 16'h0000);
        do_op(4'h7, 24'h000000, rd);
        check({14'h0, active_set}, {14'h0, SPC_SET_NONE});
        check({15'h0, in_array_read}, 16'h0001);
        array_rdata <= 16'h5A3C;
        do_op(4'h0, 24'h000777, rd);
        check(rd, 16'h5A3C);
        do_op(4'h2, 24'h000000, rd);
        check({14'h0, active_set}, {14'h0, SPC_SET_FRZ});
        do_op(4'h6, 24'h00ABCD, rd);
        check(rd, 16'hFFFF);
        do_op(4'h3, 24'h000123, rd);
        check({15'h0, persistent_bits_freeze}, 16'h0001);
        do_op(4'h6, 24'h000000, rd);
        check(rd, 16'hFFFE);
        do_op(4'h7, 24'h000000, rd);
        check({15'h0, in_array_read}, 16'h0001);
        check({15'h0, persistent_bits_freeze}, 16'h0001);
        // abort-reset leaves a set without the exit pair
        do_op(4'h1, 24'h000000, rd);
        do_op(4'h3, 24'h002800, rd);
        check(volatile_sector_bit, 16'h0020);
        do_op(4'h8, 24'h000000, rd);
        check({14'h0, active_set}, {14'h0, SPC_SET_NONE});
        check({15'h0, in_array_read}, 16'h0001);
        do_op(4'h0, 24'h000100, rd);
        check(rd, 16'h5A3C);
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        check({15'h0, persistent_bits_freeze}, 16'h0000);
        check({14'h0, active_set}, {14'h0, SPC_SET_NONE});
        check(volatile_sector_bit, 16'h0000);
        final_report();
    end
endmodule
